// ### twpwc_pkg.sv
// twpwc_pkg: constants and types shared by the wiper control block
// assumes a 100 MHz ref_clk and a separate free-running link clock
// How it works
// R1 - address byte upper nibble must equal 1010 or the device stays silent
// R2 - target bits 000 array, 111 potentiometers, 010 control/status register
// R3 - address bit zero one means read, zero means write
// R4 - stop after nonvolatile write starts 5 ms programming; commands refused
// R5 - polling address is not acknowledged while programming runs
// R6 - polling address is acknowledged after programming; transfer may go on
// R7 - three wipers with 63, 99, 255 segments, one tap enabled each
// R8 - wipers are volatile and reload from backup store at power-up
// R9 - before recall wipers hold 63, 0 and 255
// R10 - new tap switch turns on before the old one turns off
// R11 - recall waits until supply stays above threshold for power-on interval
// R12 - nonvolatile write updates wiper and backup store together
// R13 - volatile write updates only the wiper; backup store unchanged
// R14 - master writes address, instruction byte, then data byte
// R15 - read is address, instruction, repeated address; wiper value returned
// R16 - second byte is an instruction only for the potentiometer target
// R17 - instruction low two bits select potentiometer zero to two
// R18 - instruction top bit picks write type on writes, ignored on reads
// R19 - master sets the write enable latch before any wiper write
// R20 - select field value three is reserved and not acknowledged
// R21 - data byte lands in wiper on rising clock after its last bit
// R22 - data above the top tap saturates at the top tap, never wraps
// R23 - address with matching type but undefined target is not acknowledged
package twpwc_pkg;
  localparam int unsigned REF_CLK_MHZ  = 100;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * 1000 * REF_CLK_MHZ;
  // power-on interval is programmable in the real part; plain default here
  localparam int unsigned POR_TIME_MS  = 100;
  localparam int unsigned POR_CYCLES   = POR_TIME_MS * 1000 * REF_CLK_MHZ;
  typedef logic [23:0] twpwc_cnt_type;

  localparam logic [3:0] DEV_TYPE   = 4'hA;
  localparam logic [2:0] TGT_ARRAY  = 3'h0;
  localparam logic [2:0] TGT_CTRL   = 3'h2;
  localparam logic [2:0] TGT_POT    = 3'h7;
  localparam logic       DIR_READ   = 1'h1;
  localparam int         WT_BIT     = 7;
  localparam logic [1:0] POT_RSVD   = 2'h3;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [7:0] IDLE_READ  = 8'hFF;
  localparam logic [7:0] BACKUP_RST = 8'h00;
  localparam int         NUM_POTS   = 3;
  localparam int         TAP_W      = 256;
  localparam logic [7:0] MAX_TAP  [NUM_POTS] = '{8'h3F, 8'h63, 8'hFF};
  localparam logic [7:0] INIT_TAP [NUM_POTS] = '{8'h3F, 8'h00, 8'hFF};

  typedef enum logic [1:0] {
    CMD_VOL,
    CMD_NV,
    CMD_PROG
  } twpwc_kind_type;

  typedef struct packed {
    twpwc_kind_type kind;
    logic [1:0]     pot;
    logic [7:0]     data;
  } twpwc_cmd_type;

  typedef logic [NUM_POTS-1:0][7:0] twpwc_wipers_type;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_DATA,
    ST_ACK,
    ST_RD,
    ST_RDACK
  } twpwc_state_type;
endpackage : twpwc_pkg

// ### twpwc_xfer.sv
// twpwc_xfer: toggle handshake carrying one word between two clocks
// assumes src holds no new word until src_ready returns high
`timescale 1ns/1ps
module twpwc_xfer #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         src_ce,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_ready,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  input  wire logic         dst_ce,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);
  logic         req_ff;
  logic [W-1:0] hold_ff;
  logic         ack_m_ff;
  logic         ack_s_ff;
  logic         req_m_ff;
  logic         req_s_ff;
  logic         req_d_ff;
  logic         valid_ff;
  logic [W-1:0] data_ff;
  wire          take = src_ce & src_valid & src_ready;
  wire          edge_seen = req_s_ff ^ req_d_ff;

  // hold_ff is stable whenever the far side samples it
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req_ff  <= 1'h0;
      hold_ff <= '0;
    end else if (take) begin
      req_ff  <= ~req_ff;
      hold_ff <= src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    ack_m_ff <= req_d_ff;
    ack_s_ff <= ack_m_ff;
  end

  always_ff @(posedge dst_clk) begin
    req_m_ff <= req_ff;
    req_s_ff <= req_m_ff;
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_d_ff <= 1'h0;
      valid_ff <= 1'h0;
      data_ff  <= '0;
    end else if (dst_ce) begin
      req_d_ff <= req_s_ff;
      valid_ff <= edge_seen;
      if (edge_seen) begin
        data_ff <= hold_ff;
      end
    end
  end

  assign src_ready = (req_ff == ack_s_ff);
  assign dst_valid = valid_ff;
  assign dst_data  = data_ff;
endmodule : twpwc_xfer

// ### twpwc_top.sv
// twpwc_top: two-wire slave front end and wiper control, three wipers
// assumes sda/scl pins come from an open-drain bus outside both clocks;
// link_clk is free running and much faster than scl
`timescale 1ns/1ps
module twpwc_top #(
  parameter int unsigned PROG_CYCLES = twpwc_pkg::PROG_CYCLES,
  parameter int unsigned POR_CYCLES  = twpwc_pkg::POR_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic                        link_clk,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  input  wire logic                        supply_ok,
  input  wire logic                        write_enable_latch,
  input  wire logic                        write_protect,
  output logic [63:0]                      tap_on_0,
  output logic [99:0]                      tap_on_1,
  output logic [255:0]                     tap_on_2,
  output twpwc_pkg::twpwc_wipers_type      wiper_position_register,
  output twpwc_pkg::twpwc_wipers_type      wiper_backup_store,
  output logic                             prog_busy,
  output logic                             recall_done
);
  // link domain registers
  logic                       rst_m_ff;
  logic                       rst_l_ff;
  logic                       ce_m_ff;
  logic                       ce_l_ff;
  logic                       busy_m_ff;
  logic                       busy_l_ff;
  logic                       scl_m_ff;
  logic                       scl_s_ff;
  logic                       scl_d_ff;
  logic                       sda_m_ff;
  logic                       sda_s_ff;
  logic                       sda_d_ff;
  twpwc_pkg::twpwc_state_type state_ff;
  twpwc_pkg::twpwc_state_type nxt_state;
  twpwc_pkg::twpwc_state_type after_ff;
  twpwc_pkg::twpwc_state_type nxt_after;
  logic [3:0]                 cnt_ff;
  logic [3:0]                 nxt_cnt;
  logic [7:0]                 shift_ff;
  logic [7:0]                 nxt_shift;
  logic [7:0]                 tx_ff;
  logic [7:0]                 nxt_tx;
  logic                       drive_n_ff;
  logic                       nxt_drive_n;
  logic [1:0]                 pot_ptr_ff;
  logic [1:0]                 nxt_pot_ptr;
  logic                       nv_ff;
  logic                       nxt_nv;
  logic                       nv_pend_ff;
  logic                       nxt_nv_pend;
  logic                       data_ack_ff;
  logic                       nxt_data_ack;
  logic                       tgt_pot_ff;
  logic                       nxt_tgt_pot;
  logic                       send_vld;
  twpwc_pkg::twpwc_cmd_type   send_cmd;
  logic                       send_rdy;
  twpwc_pkg::twpwc_wipers_type wipers_l;

  // ref domain registers
  logic                       sup_m_ff;
  logic                       sup_s_ff;
  twpwc_pkg::twpwc_cnt_type   por_cnt_ff;
  logic                       recalled_ff;
  twpwc_pkg::twpwc_cnt_type   prog_cnt_ff;
  logic                       busy_ff;
  logic                       armed_ff;
  logic                       cmd_vld;
  twpwc_pkg::twpwc_cmd_type   cmd;
  twpwc_pkg::twpwc_wipers_type wipers;
  twpwc_pkg::twpwc_wipers_type backups;
  logic [2:0][255:0]          taps;
  logic                       snap_rdy;

  // link side event decode
  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire start_ev = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire stop_ev  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  wire byte_in  = (cnt_ff == twpwc_pkg::BYTE_BITS);

  // address byte decode
  wire [2:0] tgt      = shift_ff[3:1];
  wire type_ok  = (shift_ff[7:4] == twpwc_pkg::DEV_TYPE);        // [R1]
  wire tgt_pot  = (tgt == twpwc_pkg::TGT_POT);                   // [R2]
  wire tgt_ok   = tgt_pot | (tgt == twpwc_pkg::TGT_ARRAY)
                | (tgt == twpwc_pkg::TGT_CTRL);                  // [R2] [R23]
  // busy refuses every address, polling included
  wire addr_ack = type_ok & tgt_ok & ~busy_l_ff;         // [R4] [R5] [R6]
  wire dir_rd   = (shift_ff[0] == twpwc_pkg::DIR_READ);          // [R3]

  // instruction byte decode
  wire [1:0] sel_in   = shift_ff[1:0];                           // [R17]
  wire instr_ok = (sel_in != twpwc_pkg::POT_RSVD);               // [R20]
  wire wt_in    = shift_ff[twpwc_pkg::WT_BIT];                   // [R18]

  // read data: wiper of the last instruction, others read as ones
  wire [7:0] wiper_sel = (pot_ptr_ff == 2'h2) ? wipers_l[2] :
                         (pot_ptr_ff == 2'h1) ? wipers_l[1] :
                                                wipers_l[0];
  wire [7:0] rd_byte   = tgt_pot_ff ? wiper_sel
                                    : twpwc_pkg::IDLE_READ;      // [R15]

  always_comb begin
    nxt_state    = state_ff;
    nxt_after    = after_ff;
    nxt_cnt      = cnt_ff;
    nxt_shift    = shift_ff;
    nxt_tx       = tx_ff;
    nxt_drive_n  = drive_n_ff;
    nxt_pot_ptr  = pot_ptr_ff;
    nxt_nv       = nv_ff;
    nxt_nv_pend  = nv_pend_ff;
    nxt_data_ack = data_ack_ff;
    nxt_tgt_pot  = tgt_pot_ff;
    send_vld     = 1'h0;
    send_cmd     = '{kind: twpwc_pkg::CMD_PROG,
                     pot:  pot_ptr_ff,
                     data: shift_ff};
    if (start_ev) begin
      // a repeated start keeps the pointer for a following read
      nxt_state    = twpwc_pkg::ST_ADDR;
      nxt_cnt      = 4'h0;
      nxt_drive_n  = 1'h1;
      nxt_data_ack = 1'h0;
    end else if (stop_ev) begin
      nxt_state   = twpwc_pkg::ST_IDLE;
      nxt_drive_n = 1'h1;
      if (nv_pend_ff) begin
        send_vld    = 1'h1;                                      // [R4]
        nxt_nv_pend = 1'h0;
      end
    end else begin
      unique case (state_ff)
        twpwc_pkg::ST_IDLE: begin
        end
        twpwc_pkg::ST_ADDR,
        twpwc_pkg::ST_INSTR,
        twpwc_pkg::ST_DATA: begin
          if (scl_rise && !byte_in) begin
            nxt_shift = {shift_ff[6:0], sda_s_ff};
            nxt_cnt   = cnt_ff + 4'h1;
          end else if (scl_fall && byte_in) begin
            nxt_state   = twpwc_pkg::ST_IDLE;
            if (state_ff == twpwc_pkg::ST_ADDR) begin
              if (addr_ack) begin
                nxt_state   = twpwc_pkg::ST_ACK;
                nxt_drive_n = 1'h0;
                nxt_tgt_pot = tgt_pot;
                // instruction only follows a pot write address
                if (dir_rd) begin
                  nxt_after = twpwc_pkg::ST_RD;                  // [R3]
                end else if (tgt_pot) begin
                  nxt_after = twpwc_pkg::ST_INSTR;               // [R16]
                end else begin
                  nxt_after = twpwc_pkg::ST_IDLE;
                end
              end
            end else if (state_ff == twpwc_pkg::ST_INSTR) begin
              if (instr_ok) begin                                // [R20]
                nxt_state   = twpwc_pkg::ST_ACK;
                nxt_drive_n = 1'h0;
                nxt_pot_ptr = sel_in;                            // [R17]
                nxt_nv      = wt_in;                             // [R18]
                nxt_after   = twpwc_pkg::ST_DATA;
              end
            end else begin
              nxt_state    = twpwc_pkg::ST_ACK;
              nxt_drive_n  = 1'h0;
              nxt_data_ack = 1'h1;
              nxt_after    = twpwc_pkg::ST_DATA;
            end
          end
        end
        twpwc_pkg::ST_ACK: begin
          if (scl_rise && data_ack_ff) begin
            // wiper update on the rising edge after the last data bit
            send_vld     = 1'h1;                                 // [R21]
            send_cmd.kind = nv_ff ? twpwc_pkg::CMD_NV
                                  : twpwc_pkg::CMD_VOL;          // [R18]
            nxt_nv_pend  = nv_pend_ff | nv_ff;
            nxt_data_ack = 1'h0;
          end else if (scl_fall) begin
            nxt_cnt   = 4'h0;
            nxt_state = after_ff;
            if (after_ff == twpwc_pkg::ST_RD) begin
              nxt_tx      = rd_byte;
              nxt_drive_n = rd_byte[7];
            end else begin
              nxt_drive_n = 1'h1;
            end
          end
        end
        twpwc_pkg::ST_RD: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (byte_in) begin
              nxt_drive_n = 1'h1;
              nxt_state   = twpwc_pkg::ST_RDACK;
            end else begin
              nxt_tx      = {tx_ff[6:0], 1'h0};
              nxt_drive_n = tx_ff[6];
            end
          end
        end
        twpwc_pkg::ST_RDACK: begin
          if (scl_rise) begin
            // master ack asks for the same wiper again
            if (!sda_s_ff) begin
              nxt_state = twpwc_pkg::ST_ACK;
              nxt_after = twpwc_pkg::ST_RD;
            end else begin
              nxt_state = twpwc_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // pin and level synchronisers, not frozen by the clock enable
  always_ff @(posedge link_clk) begin
    rst_m_ff  <= reset;
    rst_l_ff  <= rst_m_ff;
    ce_m_ff   <= clk_en;
    ce_l_ff   <= ce_m_ff;
    busy_m_ff <= busy_ff;
    busy_l_ff <= busy_m_ff;
    scl_m_ff  <= scl_in;
    sda_m_ff  <= sda_in;
  end

  always_ff @(posedge link_clk) begin
    if (rst_l_ff) begin
      scl_s_ff <= 1'h1;
      scl_d_ff <= 1'h1;
      sda_s_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end else if (ce_l_ff) begin
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l_ff) begin
      state_ff    <= twpwc_pkg::ST_IDLE;
      after_ff    <= twpwc_pkg::ST_IDLE;
      cnt_ff      <= 4'h0;
      shift_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      drive_n_ff  <= 1'h1;
      pot_ptr_ff  <= 2'h0;
      nv_ff       <= 1'h0;
      nv_pend_ff  <= 1'h0;
      data_ack_ff <= 1'h0;
      tgt_pot_ff  <= 1'h0;
    end else if (ce_l_ff) begin
      state_ff    <= nxt_state;
      after_ff    <= nxt_after;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      tx_ff       <= nxt_tx;
      drive_n_ff  <= nxt_drive_n;
      pot_ptr_ff  <= nxt_pot_ptr;
      nv_ff       <= nxt_nv;
      nv_pend_ff  <= nxt_nv_pend;
      data_ack_ff <= nxt_data_ack;
      tgt_pot_ff  <= nxt_tgt_pot;
    end
  end

  // open drain: data is always low, the enable does the signalling
  assign sda_out  = 1'h0;
  assign sda_oe_n = drive_n_ff;

  // link to ref: write and programming commands
  twpwc_xfer #(.W($bits(twpwc_pkg::twpwc_cmd_type))) u_cmd (
    .src_clk   (link_clk),
    .src_rst   (rst_l_ff),
    .src_ce    (ce_l_ff),
    .src_valid (send_vld),
    .src_data  (send_cmd),
    .src_ready (send_rdy),
    .dst_clk   (ref_clk),
    .dst_rst   (reset),
    .dst_ce    (clk_en),
    .dst_valid (cmd_vld),
    .dst_data  (cmd)
  );

  // ref to link: free-running wiper snapshot for reads
  twpwc_xfer #(.W($bits(twpwc_pkg::twpwc_wipers_type))) u_snap (
    .src_clk   (ref_clk),
    .src_rst   (reset),
    .src_ce    (clk_en),
    .src_valid (snap_rdy),
    .src_data  (wipers),
    .src_ready (snap_rdy),
    .dst_clk   (link_clk),
    .dst_rst   (rst_l_ff),
    .dst_ce    (ce_l_ff),
    .dst_valid (),
    .dst_data  (wipers_l)
  );

  // ref side control
  wire por_done  = (por_cnt_ff ==
                    twpwc_pkg::twpwc_cnt_type'(POR_CYCLES));     // [R11]
  wire recall_go = sup_s_ff & ~recalled_ff & por_done;           // [R8]
  wire kind_nv   = (cmd.kind == twpwc_pkg::CMD_NV);
  wire kind_vol  = (cmd.kind == twpwc_pkg::CMD_VOL);
  // writes need the latch; protect blocks only nonvolatile ones
  wire wr_ok     = cmd_vld & recalled_ff & write_enable_latch
                 & (kind_vol | (kind_nv & ~write_protect));      // [R19]
  wire prog_go   = cmd_vld & (cmd.kind == twpwc_pkg::CMD_PROG)
                 & armed_ff & ~busy_ff;                          // [R4]
  wire prog_end  = busy_ff & (prog_cnt_ff ==
                   twpwc_pkg::twpwc_cnt_type'(PROG_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    sup_m_ff <= supply_ok;
    sup_s_ff <= sup_m_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (reset || (clk_en && !sup_s_ff)) begin
      por_cnt_ff  <= '0;
      recalled_ff <= 1'h0;
    end else if (clk_en) begin
      if (!por_done) begin
        por_cnt_ff <= por_cnt_ff + 24'h1;                        // [R11]
      end
      if (recall_go) begin
        recalled_ff <= 1'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_ff     <= 1'h0;
      armed_ff    <= 1'h0;
      prog_cnt_ff <= '0;
    end else if (clk_en) begin
      prog_cnt_ff <= busy_ff ? prog_cnt_ff + 24'h1 : '0;         // [R4]
      if (prog_go) begin
        busy_ff  <= 1'h1;
        armed_ff <= 1'h0;
      end else begin
        busy_ff  <= busy_ff & ~prog_end;
        armed_ff <= armed_ff | (wr_ok & kind_nv);
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < twpwc_pkg::NUM_POTS; gi++) begin : g_pot
      logic [7:0]   wiper_ff;
      logic [7:0]   backup_ff;
      logic [255:0] tap_ff;
      wire  [7:0]   top = twpwc_pkg::MAX_TAP[gi];
      wire          hit = wr_ok & (cmd.pot == 2'(gi));
      wire  [7:0]   sat = (cmd.data > top) ? top : cmd.data;     // [R22]
      wire  [7:0]   nxt_wiper = !sup_s_ff ? twpwc_pkg::INIT_TAP[gi] // [R9]
                              : recall_go ? backup_ff            // [R8]
                              : hit       ? sat                  // [R13]
                              : wiper_ff;
      wire  [7:0]   nxt_backup = (hit & kind_nv) ? sat           // [R12]
                                                 : backup_ff;
      // both switches on for one cycle when the wiper moves
      wire  [255:0] nxt_tap = (256'h1 << nxt_wiper)              // [R7]
                            | ((nxt_wiper != wiper_ff)
                               ? (256'h1 << wiper_ff) : 256'h0); // [R10]

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          wiper_ff  <= twpwc_pkg::INIT_TAP[gi];                  // [R9]
          backup_ff <= twpwc_pkg::BACKUP_RST;
          tap_ff    <= 256'h1 << twpwc_pkg::INIT_TAP[gi];
        end else if (clk_en) begin
          wiper_ff  <= nxt_wiper;
          backup_ff <= nxt_backup;
          tap_ff    <= nxt_tap;
        end
      end

      assign wipers[gi]  = wiper_ff;
      assign backups[gi] = backup_ff;
      assign taps[gi]    = tap_ff;
    end
  endgenerate

  assign tap_on_0                = taps[0][63:0];
  assign tap_on_1                = taps[1][99:0];
  assign tap_on_2                = taps[2];
  assign wiper_position_register = wipers;
  assign wiper_backup_store      = backups;
  assign prog_busy               = busy_ff;
  assign recall_done             = recalled_ff;
endmodule : twpwc_top

// ### twpwc_checker.sv
// twpwc_checker: wiper side assertions for twpwc_top
// assumes it is bound into twpwc_top; ref_clk domain only
`timescale 1ns/1ps
module twpwc_checker #(
  parameter int unsigned PROG_CYCLES = 50,
  parameter int unsigned POR_CYCLES  = 20
) (
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire logic                   supply_ok,
  input wire logic [63:0]            tap_on_0,
  input wire logic [99:0]            tap_on_1,
  input wire logic [255:0]           tap_on_2,
  input twpwc_pkg::twpwc_wipers_type wiper_position_register,
  input twpwc_pkg::twpwc_wipers_type wiper_backup_store,
  input wire logic                   prog_busy,
  input wire logic                   recall_done
);
  twpwc_pkg::twpwc_wipers_type w;
  twpwc_pkg::twpwc_wipers_type b;
  int unsigned                 busy_ff;
  int unsigned                 up_ff;
  assign w = wiper_position_register;
  assign b = wiper_backup_store;
  // raw supply time is longer than the synced one, so the bound is safe
  always_ff @(posedge ref_clk) begin
    busy_ff <= prog_busy ? busy_ff + 1 : 0;
    up_ff   <= supply_ok ? up_ff + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  start_value_a: assert property (!recall_done |-> w == 24'hFF003F)
    else $error("wiper off start value");
  tap_select_a: assert property (tap_on_0[w[0][5:0]] &&
    $countones(tap_on_0) inside {1, 2}) else $error("tap decode wrong");
  mid_tap_a: assert property (tap_on_1[w[1][6:0]] &&
    $countones(tap_on_1) inside {1, 2}) else $error("mid tap decode wrong");
  make_break_a: assert property ($changed(w[2]) |->
    $countones(tap_on_2) == 2 ##1 $countones(tap_on_2) == 1)
    else $error("no tap overlap");
  tap_limit_a: assert property (w[0] <= 8'h3F && w[1] <= 8'h63)
    else $error("wiper past top tap");
  backup_pair_a: assert property ($changed(b[2]) |-> b[2] == w[2])
    else $error("backup apart from wiper");
  recall_load_a: assert property ($rose(recall_done) |-> w == b)
    else $error("recall value wrong");
  recall_wait_a: assert property ($rose(recall_done) |->
    up_ff > POR_CYCLES) else $error("recall too early");
  prog_length_a: assert property ($fell(prog_busy) |->
    busy_ff >= PROG_CYCLES - 1 && busy_ff <= PROG_CYCLES + 1)
    else $error("busy length wrong");
  cover property ($rose(prog_busy));
  cover property ($rose(recall_done));
  cover property ($countones(tap_on_2) == 2);
endmodule : twpwc_checker
bind twpwc_top twpwc_checker #(.PROG_CYCLES(PROG_CYCLES),
  .POR_CYCLES(POR_CYCLES)) u_chk (.ref_clk, .reset, .supply_ok, .tap_on_0,
  .tap_on_2, .wiper_position_register, .wiper_backup_store, .prog_busy,
  .recall_done, .tap_on_1);

// ### twpwc_master.sv
// twpwc_master: behavioural two-wire bus master
// assumes a pull-up on sda; sda_drv high releases the line
`timescale 1ns/1ps
module twpwc_master #(
  parameter time HALF = 480ns
) (
  output logic     scl,
  output logic     sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // sda moves a quarter phase after scl falls, so no false start or stop
  task automatic bit_io(input logic v, output logic s);
    #(HALF/4) sda_drv = v;
    #HALF scl = 1'b1;
    #(HALF/2) s = sda;
    #(HALF/2) scl = 1'b0;
  endtask : bit_io
  // also a repeated start when scl is low on entry
  task automatic start();
    #(HALF/4) sda_drv = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask : start
  task automatic stop();
    #(HALF/4) sda_drv = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask : stop
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put
  // no acknowledge after the byte ends the read
  task automatic get(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
  endtask : get
endmodule : twpwc_master

// ### tb_two_wire_pot_wiper_control.sv
// tb_two_wire_pot_wiper_control: self-checking bench for twpwc_top
// assumes twpwc_master on the bus and shortened programming counts
`timescale 1ns/1ps
module tb_two_wire_pot_wiper_control;
  typedef struct packed {
    logic [7:0] ins;
    logic [7:0] dat;
    logic [7:0] wpr;
    logic [7:0] bkp;
  } twpwc_row_type;
  // instruction, data, wiper and backup expected
  localparam twpwc_row_type ROWS [6] = '{32'h00151500, 32'h81706363,
    32'h82202020, 32'h02C0C020, 32'h80503F3F, 32'h010A0A63};
  // ack expected, then address byte
  localparam logic [8:0] ADRS [5] = '{9'h05E, 9'h0A6, 9'h1A0, 9'h1A4,
    9'h1A5};
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic supply_ok = 1'b1;
  logic write_enable_latch = 1'b1;
  logic scl_in;
  logic sda_drv;
  logic sda_out;
  logic sda_oe_n;
  logic prog_busy;
  logic recall_done;
  twpwc_pkg::twpwc_wipers_type w;
  twpwc_pkg::twpwc_wipers_type b;
  wire sda_in = sda_drv & (sda_oe_n | sda_out);
  int num_errors = 0;
  int n_compared = 0;
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  twpwc_top #(.PROG_CYCLES(2000), .POR_CYCLES(20)) DUT (.ref_clk, .reset,
    .clk_en(1'b1), .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .supply_ok, .write_enable_latch, .write_protect(1'b0), .tap_on_0(),
    .tap_on_1(), .tap_on_2(), .wiper_position_register(w),
    .wiper_backup_store(b), .prog_busy, .recall_done);
  twpwc_master MST (.scl(scl_in), .sda_drv, .sda(sda_in));
  task automatic chk(input string what, input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic wait_for(input string what, ref logic sig, input logic lv);
    for (int i = 0; i < 5000 && sig !== lv; i++) @(posedge ref_clk);
    if (sig !== lv) begin
      chk(what, sig, lv);
      final_report();
    end
  endtask : wait_for
  task automatic wr(input logic [7:0] ins, dat, input logic [2:0] exp);
    logic [2:0] a;
    MST.start();
    MST.put(8'hAE, a[2]);
    MST.put(ins, a[1]);
    MST.put(dat, a[0]);
    MST.stop();
    chk("write acks", a, exp);
  endtask : wr
  task automatic rd(input logic [7:0] ins, output logic [7:0] q);
    logic [2:0] a;
    MST.start();
    MST.put(8'hAE, a[2]);
    MST.put(ins, a[1]);
    MST.start();
    MST.put(8'hAF, a[0]);
    MST.get(q);
    MST.stop();
    chk("read acks", a, 3'h7);
  endtask : rd
  task automatic poll(input logic [7:0] adr, input logic exp);
    logic a;
    MST.start();
    MST.put(adr, a);
    MST.stop();
    chk("address ack", a, exp);
  endtask : poll
  initial begin : main
    logic [7:0] q;
    // longer than twelve cycles: the link side needs four of its own edges
    repeat (13) @(posedge ref_clk);
    chk("start wipers", w, 24'hFF003F);
    #1 reset = 1'b0;
    wait_for("recall", recall_done, 1'b1);
    chk("recalled", w, 24'h0);
    foreach (ROWS[r]) begin
      wr(ROWS[r].ins, ROWS[r].dat, 3'h7);
      wait_for("busy", prog_busy, 1'b0);
      chk("wiper", w[ROWS[r].ins[1:0]], ROWS[r].wpr);
      chk("backup", b[ROWS[r].ins[1:0]], ROWS[r].bkp);
      rd(ROWS[r].ins ^ 8'h80, q);
      chk("read", q, ROWS[r].wpr);
    end
    foreach (ADRS[i]) poll(ADRS[i][7:0], ADRS[i][8]);
    wr(8'h83, 8'h11, 3'h4);
    wr(8'h82, 8'h7B, 3'h7);
    poll(8'hAE, 1'b0);
    wait_for("busy", prog_busy, 1'b0);
    poll(8'hAE, 1'b1);
    rd(8'h02, q);
    chk("after poll", q, 8'h7B);
    @(posedge ref_clk) #1 write_enable_latch = 1'b0;
    wr(8'h00, 8'h01, 3'h7);
    chk("locked wiper", w[0], 8'h3F);
    @(posedge ref_clk) #1 write_enable_latch = 1'b1;
    supply_ok = 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("cycled wipers", w, 24'hFF003F);
    #1 supply_ok = 1'b1;
    wait_for("recall", recall_done, 1'b1);
    chk("recalled", w, 24'h7B633F);
    chk("kept backup", b, 24'h7B633F);
    final_report();
  end
endmodule : tb_two_wire_pot_wiper_control
